/* core/fsl_consts.svh */
/*
  Named constants of the fieldbus status indicator driver: clock and tick timing,
  pattern phase lengths, slave state codes and counter widths.
  Assumes it is included by bare name wherever a constant is used.
*/
`ifndef FSL_CONSTS_SVH
`define FSL_CONSTS_SVH

// Clock and millisecond tick
`define FSL_CLK_PERIOD_PS     25000
`define FSL_TICK_PERIOD_MS    1
`define FSL_PS_PER_MS         1000000000
`define FSL_TICK_CNT_W        16

// Pattern phase lengths in milliseconds
`define FSL_FLICKER_MS        10'd50
`define FSL_BLINK_MS          10'd200
`define FSL_FLASH_ON_MS       10'd200
`define FSL_FLASH_OFF_MS      10'd1000
`define FSL_MS_CNT_W          10
`define FSL_STEP_W            2

// Activity on a port is stretched so that single frames still flicker visibly
`define FSL_ACT_HOLD_MS       7'd100
`define FSL_ACT_CNT_W         7

// Slave state machine codes as presented by the slave controller
`define FSL_STATE_W           4
`define FSL_ST_INIT           4'h1
`define FSL_ST_PREOP          4'h2
`define FSL_ST_BOOT           4'h3
`define FSL_ST_SAFEOP         4'h4
`define FSL_ST_OP             4'h8

// Indicator channels
`define FSL_NUM_PORTS         2
`define FSL_NUM_CHAN          4
`define FSL_CH_RUN            0
`define FSL_CH_ERR            1
`define FSL_CH_LINK0          2

`endif

/* core/fsl_pkg.sv */
/*
  Types of the fieldbus status indicator driver.
  Assumes fsl_consts.svh sits beside it for the numeric constants.
*/
package fsl_pkg;

  // Indicator patterns; each non-constant one begins with its lit phase
  typedef enum logic [2:0] {
    PAT_OFF,
    PAT_ON,
    PAT_FLICKER,
    PAT_BLINK,
    PAT_SINGLE,
    PAT_DOUBLE
  } fsl_pat_t;

endpackage

/* core/fsl_pat_if.sv */
/*
  Link between the indicator top and one pattern generator: the shared
  millisecond tick, the pattern to show, and the resulting indicator level.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface fsl_pat_if;
  import fsl_pkg::*;

  logic     tick;
  fsl_pat_t pat;
  logic     led;

  modport gen (input tick, input pat, output led);
  modport src (output tick, output pat, input led);
endinterface

/* core/fsl_pattern_gen.sv */
/*
  One indicator pattern generator: steps through lit and dark phases counted
  in millisecond ticks and restarts at the lit phase when the pattern changes.
  Assumes the tick is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
`include "fsl_consts.svh"
module fsl_pattern_gen
  import fsl_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Pattern link
  fsl_pat_if.gen   bus
);

  logic [`FSL_MS_CNT_W-1:0] msCnt_ff;
  logic [`FSL_MS_CNT_W-1:0] nxt_msCnt;
  logic [`FSL_STEP_W-1:0]   step_ff;
  logic [`FSL_STEP_W-1:0]   nxt_step;
  fsl_pat_t                 last_ff;
  fsl_pat_t                 nxt_last;
  logic                     led_ff;
  logic                     nxt_led;

  ////////////////////////////////////////////////////////////////////////////
  // Phase length of each step; even steps are lit, odd steps dark
  function automatic logic [`FSL_MS_CNT_W-1:0] stepLen(input fsl_pat_t p, input logic [`FSL_STEP_W-1:0] s);
    logic [`FSL_MS_CNT_W-1:0] len;
    len = `FSL_BLINK_MS;
    case (p)
      PAT_FLICKER: len = `FSL_FLICKER_MS; // RQ15
      PAT_BLINK:   len = `FSL_BLINK_MS;
      PAT_SINGLE:  len = s[0] ? `FSL_FLASH_OFF_MS : `FSL_FLASH_ON_MS;
      PAT_DOUBLE:  len = (s == 2'h3) ? `FSL_FLASH_OFF_MS : `FSL_FLASH_ON_MS; // RQ15
      default:     len = `FSL_BLINK_MS;
    endcase
    return len;
  endfunction

  function automatic logic [`FSL_STEP_W-1:0] lastStep(input fsl_pat_t p);
    return (p == PAT_DOUBLE) ? 2'h3 : 2'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_msCnt = msCnt_ff;
    nxt_step  = step_ff;
    nxt_last  = bus.pat;
    if (bus.pat != last_ff) begin
      nxt_msCnt = '0; // RQ17
      nxt_step  = '0;
    end else if (bus.tick) begin
      if (msCnt_ff >= stepLen(bus.pat, step_ff) - 10'h001) begin
        nxt_msCnt = '0;
        nxt_step  = (step_ff >= lastStep(bus.pat)) ? 2'h0 : step_ff + 2'h1;
      end else begin
        nxt_msCnt = msCnt_ff + 10'h001;
      end
    end
    case (bus.pat)
      PAT_OFF: nxt_led = 1'b0;
      PAT_ON:  nxt_led = 1'b1;
      default: nxt_led = ~nxt_step[0];
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      msCnt_ff <= '0;
      step_ff  <= '0;
      last_ff  <= PAT_OFF;
      led_ff   <= 1'b0; // RQ17
    end else begin
      msCnt_ff <= nxt_msCnt;
      step_ff  <= nxt_step;
      last_ff  <= nxt_last;
      led_ff   <= nxt_led;
    end
  end

  assign bus.led = led_ff;

endmodule

/* core/fsl_status_led.sv */
/*
  Fieldbus status indicator driver: run, error and per-port link/activity
  indicators of the network interface, with the automatic drop to
  safe-operational on a synchronisation error.
  Assumes all status inputs come from slave controller logic on this clock.

  // How it works
  // RQ1 - Run indicator dark while slave is in init.
  // RQ2 - Run indicator blinks 200 ms lit, 200 ms dark in pre-operational.
  // RQ3 - Run indicator single-flashes 200 ms lit, 1000 ms dark in safe-operational.
  // RQ4 - Run indicator steadily lit in operational.
  // RQ5 - Run indicator flickers while booting, before init is reached.
  // RQ6 - Error indicator dark when no error is present.
  // RQ7 - Error indicator flickers on a booting error.
  // RQ8 - Error indicator blinks 200/200 ms on an impossible state change request.
  // RQ9 - Sync error forces safe-operational and single-flashes the error indicator.
  // RQ10 - Error indicator double-flashes on sync-manager watchdog timeout.
  // RQ11 - Error indicator steadily lit on process data interface watchdog timeout.
  // RQ12 - Link indicator dark without cable or with controller not started.
  // RQ13 - Link indicator flickers while frames are exchanged on that port.
  // RQ14 - Link indicator steadily lit with link but no traffic.
  // RQ15 - Flicker is 50/50 ms; double flash is 200,200,200 lit-dark-lit then 1000 dark.
  // RQ16 - Simultaneous errors show only the highest-priority one.
  // RQ17 - One millisecond tick times everything; patterns restart lit; reset clears indicators.
*/
`timescale 1ns/1ps
`include "fsl_consts.svh"
module fsl_status_led
  import fsl_pkg::*;
#(
  parameter int TICK_CYCLES = (`FSL_TICK_PERIOD_MS * `FSL_PS_PER_MS) / `FSL_CLK_PERIOD_PS
)
(
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // Slave state and controller status
  input  wire logic [`FSL_STATE_W-1:0]  slaveState,
  input  wire logic                     ctrlStarted,
  // Error conditions, levels
  input  wire logic                     bootErr,
  input  wire logic                     badStateReq,
  input  wire logic                     syncErr,
  input  wire logic                     smWatchdog,
  input  wire logic                     pdiWatchdog,
  // Port status
  input  wire logic [`FSL_NUM_PORTS-1:0] linkUp,
  input  wire logic [`FSL_NUM_PORTS-1:0] frameSeen,
  // Requests to the slave state machine
  output logic                          safeOpReq,
  // Indicators, high is lit
  output logic                          runLed,
  output logic                          errLed,
  output logic [`FSL_NUM_PORTS-1:0]     linkLed
);

  ////////////////////////////////////////////////////////////////////////////
  // Free-running millisecond tick shared by all generators
  logic [`FSL_TICK_CNT_W-1:0] tickCnt_ff;
  logic [`FSL_TICK_CNT_W-1:0] nxt_tickCnt;
  logic                       tick_ff;
  logic                       nxt_tick;

  always_comb begin
    nxt_tick    = 1'b0;
    nxt_tickCnt = tickCnt_ff + 16'h0001;
    if (tickCnt_ff >= `FSL_TICK_CNT_W'(TICK_CYCLES - 1)) begin
      nxt_tickCnt = '0; // RQ17
      nxt_tick    = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tickCnt_ff <= '0;
      tick_ff    <= 1'b0;
    end else begin
      tickCnt_ff <= nxt_tickCnt;
      tick_ff    <= nxt_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run indicator pattern from the slave state
  fsl_pat_t runPat;

  always_comb begin
    case (slaveState)
      `FSL_ST_INIT:   runPat = PAT_OFF;     // RQ1
      `FSL_ST_PREOP:  runPat = PAT_BLINK;   // RQ2
      `FSL_ST_SAFEOP: runPat = PAT_SINGLE;  // RQ3
      `FSL_ST_OP:     runPat = PAT_ON;      // RQ4
      `FSL_ST_BOOT:   runPat = PAT_FLICKER; // RQ5
      default:        runPat = PAT_OFF;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error indicator pattern, highest priority first
  fsl_pat_t errPat;

  always_comb begin
    if (pdiWatchdog) begin
      errPat = PAT_ON;      // RQ11 RQ16
    end else if (smWatchdog) begin
      errPat = PAT_DOUBLE;  // RQ10 RQ16
    end else if (syncErr) begin
      errPat = PAT_SINGLE;  // RQ9 RQ16
    end else if (badStateReq) begin
      errPat = PAT_BLINK;   // RQ8 RQ16
    end else if (bootErr) begin
      errPat = PAT_FLICKER; // RQ7 RQ16
    end else begin
      errPat = PAT_OFF;     // RQ6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Safe-operational request on a new sync error while above safe-operational
  logic syncPrev_ff;
  logic nxt_syncPrev;
  logic safeOpReq_ff;
  logic nxt_safeOpReq;

  always_comb begin
    nxt_syncPrev  = syncErr;
    nxt_safeOpReq = syncErr & ~syncPrev_ff & (slaveState == `FSL_ST_OP); // RQ9
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      syncPrev_ff  <= 1'b0;
      safeOpReq_ff <= 1'b0;
    end else begin
      syncPrev_ff  <= nxt_syncPrev;
      safeOpReq_ff <= nxt_safeOpReq;
    end
  end

  assign safeOpReq = safeOpReq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Per-port activity stretch and link pattern
  fsl_pat_t linkPat [`FSL_NUM_PORTS];

  genvar p;
  generate
    for (p = 0; p < `FSL_NUM_PORTS; p++) begin : g_port
      logic [`FSL_ACT_CNT_W-1:0] actCnt_ff;
      logic [`FSL_ACT_CNT_W-1:0] nxt_actCnt;

      always_comb begin
        nxt_actCnt = actCnt_ff;
        if (frameSeen[p]) begin
          nxt_actCnt = `FSL_ACT_HOLD_MS;
        end else if (tick_ff && (actCnt_ff != '0)) begin
          nxt_actCnt = actCnt_ff - 7'h01;
        end
        if (!ctrlStarted || !linkUp[p]) begin
          linkPat[p] = PAT_OFF;     // RQ12
        end else if (frameSeen[p] || (actCnt_ff != '0)) begin
          linkPat[p] = PAT_FLICKER; // RQ13
        end else begin
          linkPat[p] = PAT_ON;      // RQ14
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          actCnt_ff <= '0;
        end else begin
          actCnt_ff <= nxt_actCnt;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pattern generators, one per indicator
  fsl_pat_if chan [`FSL_NUM_CHAN] ();
  fsl_pat_t  chanPat [`FSL_NUM_CHAN];
  logic [`FSL_NUM_CHAN-1:0] chanLed;

  assign chanPat[`FSL_CH_RUN] = runPat;
  assign chanPat[`FSL_CH_ERR] = errPat;

  genvar c;
  generate
    for (c = 0; c < `FSL_NUM_PORTS; c++) begin : g_linkmap
      assign chanPat[`FSL_CH_LINK0 + c] = linkPat[c];
    end
    for (c = 0; c < `FSL_NUM_CHAN; c++) begin : g_chan
      assign chan[c].tick = tick_ff; // RQ17
      assign chan[c].pat  = chanPat[c];
      assign chanLed[c]   = chan[c].led;
      fsl_pattern_gen u_gen (
        .clock (clock),
        .rst   (rst),
        .bus   (chan[c])
      );
    end
  endgenerate

  assign runLed  = chanLed[`FSL_CH_RUN];
  assign errLed  = chanLed[`FSL_CH_ERR];
  assign linkLed = chanLed[`FSL_CH_LINK0 +: `FSL_NUM_PORTS];

endmodule

/* tb/fsl_status_led_asserts.sv */
/*
  Port checker of the status indicator driver.
  Assumes it is bound with the same TICK_CYCLES as the driver instance.
*/
`timescale 1ns/1ps
`include "fsl_consts.svh"
module fsl_status_led_asserts #(
  parameter int TICK_CYCLES = 4
)
(
  // Clock and reset
  input wire logic                      clock,
  input wire logic                      rst,
  // Status inputs
  input wire logic [`FSL_STATE_W-1:0]   slaveState,
  input wire logic                      ctrlStarted,
  input wire logic                      bootErr,
  input wire logic                      badStateReq,
  input wire logic                      syncErr,
  input wire logic                      smWatchdog,
  input wire logic                      pdiWatchdog,
  input wire logic [`FSL_NUM_PORTS-1:0] linkUp,
  input wire logic [`FSL_NUM_PORTS-1:0] frameSeen,
  // Outputs
  input wire logic                      safeOpReq,
  input wire logic                      runLed,
  input wire logic                      errLed,
  input wire logic [`FSL_NUM_PORTS-1:0] linkLed
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Run length of the run level; state is delayed twice to match the output latency
  logic [31:0] litRun_ff;
  logic [31:0] nxt_litRun;
  logic        ledQ_ff;
  logic [3:0]  stQ_ff;
  logic [3:0]  stQ2_ff;
  always_comb begin
    nxt_litRun = (runLed == ledQ_ff && stQ_ff == stQ2_ff) ? litRun_ff + 32'h1 : 32'h1;
  end
  // The run length restarts on reset so that no unknown survives into the checks
  always_ff @(posedge clock) begin
    if (rst) begin
      litRun_ff <= 32'h1;
    end else begin
      litRun_ff <= nxt_litRun;
    end
    ledQ_ff   <= runLed;
    stQ_ff    <= slaveState;
    stQ2_ff   <= stQ_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_reset_clears: assert property (
    $fell(rst) |-> !runLed && !errLed && linkLed == 2'h0 && !safeOpReq) else $error("outputs not clear after reset");
  a_init_dark: assert property (
    slaveState == `FSL_ST_INIT |=> !runLed) else $error("run lit in init");
  a_op_lit: assert property (
    slaveState == `FSL_ST_OP |=> runLed) else $error("run dark in operational");
  a_blink_phase: assert property (
    stQ2_ff == `FSL_ST_PREOP |-> litRun_ff <= 200 * TICK_CYCLES) else $error("blink phase too long");
  a_flash_phase: assert property (
    stQ2_ff == `FSL_ST_SAFEOP |-> litRun_ff <= (ledQ_ff ? 200 : 1000) * TICK_CYCLES)
    else $error("single flash phase too long");
  a_no_err_dark: assert property (
    !(bootErr || badStateReq || syncErr || smWatchdog || pdiWatchdog) |=> !errLed) else $error("error lit");
  a_pdi_lit: assert property (
    pdiWatchdog |=> errLed) else $error("error dark on interface watchdog");
  a_link_off: assert property (
    !ctrlStarted || !linkUp[1] |=> !linkLed[1]) else $error("link lit without link");
  a_safeop_pulse: assert property (
    $rose(syncErr) && slaveState == `FSL_ST_OP |=> safeOpReq ##1 !safeOpReq) else $error("no request pulse");
  a_safeop_cause: assert property (
    safeOpReq |-> $past(syncErr) && !$past(syncErr, 2) && $past(slaveState) == `FSL_ST_OP)
    else $error("request without cause");
endmodule

bind fsl_status_led fsl_status_led_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clock(clock), .rst(rst), .slaveState(slaveState), .ctrlStarted(ctrlStarted), .bootErr(bootErr),
  .badStateReq(badStateReq), .syncErr(syncErr), .smWatchdog(smWatchdog), .pdiWatchdog(pdiWatchdog),
  .linkUp(linkUp), .frameSeen(frameSeen), .safeOpReq(safeOpReq), .runLed(runLed), .errLed(errLed),
  .linkLed(linkLed));

/* tb/fsl_led_observer.sv */
/*
  Operator model: watches one indicator and keeps the length of its last lit
  phase and its last two dark phases, in clock cycles.
  Assumes the indicator is sampled on the driver's clock.
*/
`timescale 1ns/1ps
module fsl_led_observer (
  // Clock and watched indicator
  input  wire logic  clock,
  input  wire logic  led,
  // Finished phase lengths
  output logic [15:0] onLen,
  output logic [15:0] offLen,
  output logic [15:0] offPrev
);
  logic [15:0] run  = 16'h0;
  logic        last = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (led !== last) begin
      if (last) begin
        onLen <= run;
      end else begin
        offPrev <= offLen;
        offLen  <= run;
      end
      run <= 16'h1;
    end else begin
      run <= run + 16'h1;
    end
    last <= led;
  end
endmodule

/* tb/fsl_status_led_tb_top.sv */
/*
  Self-checking bench of the status indicator driver.
  Assumes a shortened tick of 4 clocks stands for one millisecond.
*/
`timescale 1ns/1ps
`include "fsl_consts.svh"
module fsl_status_led_tb_top;
  localparam int TC = 4;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  slaveState = `FSL_ST_INIT;
  logic        ctrlStarted = 1'b0;
  logic [4:0]  errs = 5'h0;
  logic [1:0]  linkUp = 2'h0;
  logic [1:0]  frameSeen = 2'h0;
  logic        safeOpReq, runLed, errLed;
  logic [1:0]  linkLed;
  logic [15:0] onR, offR, prvR, onE, offE, prvE, onL, offL, prvL;
  int          mismatches = 0;
  int          checkCount = 0;

  fsl_status_led #(.TICK_CYCLES(TC)) u_dut (
    .clock(clock), .rst(rst), .slaveState(slaveState), .ctrlStarted(ctrlStarted), .pdiWatchdog(errs[4]),
    .smWatchdog(errs[3]), .syncErr(errs[2]), .badStateReq(errs[1]), .bootErr(errs[0]), .linkUp(linkUp),
    .frameSeen(frameSeen), .safeOpReq(safeOpReq), .runLed(runLed), .errLed(errLed), .linkLed(linkLed));
  fsl_led_observer u_obsRun (.clock(clock), .led(runLed), .onLen(onR), .offLen(offR), .offPrev(prvR));
  fsl_led_observer u_obsErr (.clock(clock), .led(errLed), .onLen(onE), .offLen(offE), .offPrev(prvE));
  fsl_led_observer u_obsLnk (.clock(clock), .led(linkLed[0]), .onLen(onL), .offLen(offL), .offPrev(prvL));

  initial forever #12.5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  // Waits two lit phases plus offMs plus 60 ms; offMs is the sum of two dark phases, or the steady level when onMs is 0
  task automatic pat(input int sel, input int onMs, input int offMs);
    logic        lvl;
    logic [15:0] on, off, prv;
    cyc((2 * onMs + offMs + 60) * TC);
    lvl = sel ? errLed : runLed;
    on  = sel ? onE : onR;
    off = sel ? offE : offR;
    prv = sel ? prvE : prvR;
    if (onMs == 0) check({31'h0, lvl}, 32'(offMs));
    else begin
      check({16'h0, on}, 32'(onMs * TC));
      check({16'h0, off} + prv, 32'(offMs * TC));
    end
  endtask

  task automatic count_req(output int n);
    n = 0;
    repeat (6) begin
      cyc(1);
      n += (safeOpReq === 1'b1);
    end
  endtask

  task automatic t_run;
    slaveState = `FSL_ST_PREOP;
    pat(0, 200, 400);
    slaveState = `FSL_ST_SAFEOP;
    pat(0, 200, 2000);
    slaveState = `FSL_ST_OP;
    pat(0, 0, 1);
    slaveState = `FSL_ST_BOOT;
    pat(0, 50, 100);
    slaveState = `FSL_ST_INIT;
    pat(0, 0, 0);
  endtask

  // Drops the highest error each step
  task automatic t_err;
    errs = 5'h1f;
    pat(1, 0, 1);
    errs = 5'h0f;
    pat(1, 200, 1200);
    errs = 5'h07;
    pat(1, 200, 2000);
    errs = 5'h03;
    pat(1, 200, 400);
    errs = 5'h01;
    pat(1, 50, 100);
    errs = 5'h00;
    pat(1, 0, 0);
  endtask

  task automatic t_safeop;
    int n;
    slaveState = `FSL_ST_OP;
    cyc(2);
    errs = 5'h04;
    count_req(n);
    check(32'(n), 32'h1);
    errs = 5'h00;
    slaveState = `FSL_ST_SAFEOP;
    cyc(2);
    errs = 5'h04;
    count_req(n);
    check(32'(n), 32'h0);
    errs = 5'h00;
  endtask

  task automatic t_link;
    linkUp = 2'h3;
    cyc(3);
    check({30'h0, linkLed}, 32'h0);
    ctrlStarted = 1'b1;
    linkUp = 2'h1;
    cyc(110 * TC);
    check({30'h0, linkLed}, 32'h1);
    linkUp = 2'h3;
    repeat (20) begin
      frameSeen = 2'h1;
      cyc(1);
      frameSeen = 2'h0;
      cyc(20 * TC - 1);
    end
    check({16'h0, onL}, 32'(50 * TC));
    check({16'h0, offL} + prvL, 32'(100 * TC));
    cyc(160 * TC);
    check({30'h0, linkLed}, 32'h3);
  endtask

  // Second reset in mid-run with every indicator lit
  task automatic t_reset;
    slaveState = `FSL_ST_OP;
    errs = 5'h10;
    cyc(4);
    rst = 1'b1;
    cyc(2);
    check({27'h0, runLed, errLed, linkLed, safeOpReq}, 32'h0);
    rst = 1'b0;
    cyc(3);
    check({30'h0, runLed, errLed}, 32'h3);
  endtask

  task automatic complete_run;
    $display("Checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    cyc(6);
    check({27'h0, runLed, errLed, linkLed, safeOpReq}, 32'h0);
    rst = 1'b0;
    t_run();
    t_err();
    t_safeop();
    t_link();
    t_reset();
    complete_run();
  end

  // The whole run needs about 40000 cycles
  initial begin
    repeat (80000) @(posedge clock);
    mismatches++;
    complete_run();
  end
endmodule
